//--- nfcab_card_model.sv
// nfcab_card_model: behavioural card facing the codec's rf pins.
// assumes a 20 MHz ref_clk; rx_sub is an async pin timed in real time.
`timescale 1ns/100ps
module nfcab_card_model (
  input wire logic ref_clk, // 20 MHz
  input wire logic mod_full, // reader full pause
  input wire logic mod_low10, // reader ten percent level
  output logic rx_sub // card load modulation
);
  // ==========================================================
  // recorder of the reader keying
  int t = 0; // ref cycles seen
  int np = 0; // pauses seen
  int ps [0:63]; // pause start cycles
  int w0 = 0; // width of first pause
  int n_full = 0; // cycles in full pause
  int n_low = 0; // cycles at ten percent
  int run10 = 0; // length of first ten percent run
  bit run_done = 1'b0; // first run closed
  logic pf_q = 1'b0; // mod_full one cycle ago
  initial rx_sub = 1'b0; // no load between frames
  // samples the keying once per ref cycle
  always @(posedge ref_clk) begin
    t++;
    if (mod_full === 1'b1 && pf_q !== 1'b1 && np < 64) begin // pause starts
      ps[np] = t;
      np++;
    end
    if (mod_full !== 1'b1 && pf_q === 1'b1 && np == 1) w0 = t - ps[0];
    if (mod_full === 1'b1) n_full++;
    if (mod_low10 === 1'b1) begin
      n_low++;
      if (!run_done) run10++;
    end else if (run10 > 0) begin
      run_done = 1'b1;
    end
    pf_q = mod_full;
  end
  // forget the previous frame
  function automatic void clear();
    np = 0;
    w0 = 0;
    n_full = 0;
    n_low = 0;
    run10 = 0;
    run_done = 1'b0;
  endfunction
  // ==========================================================
  // modified miller read back: a pause at an odd half-bit is a 1
  function automatic logic [39:0] decode(input int sp);
    real h;
    int pos;
    logic [39:0] v;
    h = real'(64 >> sp) * 20000.0 / 13560.0;
    v = '0;
    for (int k = 1; k < np; k++) begin
      pos = $rtoi(real'(ps[k] - ps[0]) / h + 0.5);
      if (pos % 2 == 1 && pos < 80) v[pos / 2] = 1'b1;
    end
    return v;
  endfunction
  // type A crc, reflected, lsb first
  function automatic logic [15:0] crc_a(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h6363;
    foreach (b[i]) begin
      for (int j = 0; j < 8; j++) begin
        c = ((c[0] ^ b[i][j]) == 1'b1) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return c;
  endfunction
  // ==========================================================
  // one half-bit: four subcarrier periods at fc/16
  task automatic half(input bit load);
    repeat (4) begin
      rx_sub = load;
      #590.0;
      rx_sub = 1'b0;
      #590.0;
    end
  endtask
  // 106k type A answer; bad_par picks a byte whose parity is inverted
  task automatic send_a(input logic [7:0] b[$], input int bad_par);
    bit p;
    half(1'b1);
    half(1'b0);
    foreach (b[i]) begin
      for (int j = 0; j < 9; j++) begin
        p = (j < 8) ? b[i][j] : ((~^b[i]) ^ (i == bad_par));
        half(p);
        half(!p);
      end
    end
    repeat (4) half(1'b0);
  endtask
endmodule

//--- nfcab_codec.sv
// nfcab_codec: type A / type B reader framing, coding and decoding.
// assumes host strobes on ref_clk; rx_sub is an async comparator pin.
// Contract
// [RL1] type A sends modified Miller, full pauses
// [RL2] type A bit is 128/64/32/16 carrier cycles
// [RL3] type A receive Manchester at 106, else BPSK
// [RL4] frame crc generated and checked in hardware
// [RL5] type A parity internal, per selected speed
// [RL6] type B sends NRZ, ten percent keying
// [RL7] type B receive BPSK fc/16 subcarrier
// [RL8] host runs type A higher protocol layers
// [RL9] host runs whole type B protocol flow
// [RL10] frame start flag on receive start
// [RL11] transmit done flag entering end of frame
// [RL12] error flag when any error bit sets
// [RL13] odd parity per byte, mismatch flagged
`timescale 1ns/100ps
module nfcab_codec import nfcab_pkg::*; (
  input wire logic ref_clk, // 20 MHz
  input wire logic rst, // async, high
  input wire logic mode_b, // 1 type B, 0 type A
  input wire logic [1:0] speed, // 0..3 = 106..848 kbit/s
  input wire logic tx_valid, // host byte offered
  input wire logic [7:0] tx_data, // host byte
  input wire logic tx_last, // byte ends the frame
  output logic tx_ready, // byte taken when valid
  input wire logic rx_sub, // load modulation pin
  output logic [7:0] rx_data, // received byte
  output logic rx_valid, // rx_data strobe
  output logic rx_end, // end of received frame
  output logic mod_full, // full-depth pause
  output logic mod_low10, // ten percent level
  input wire logic [2:0] flag_clr, // clear flags, bit 2 also errors
  output logic rx_frame_start_flag, // sticky
  output logic tx_done_flag, // sticky
  output logic rx_error_flag, // sticky
  output logic [2:0] err_status // parity, crc, framing
);
  nfcab_st_type s, n; // state and next
  nfcab_crc_if crc_bus(); // link to crc unit
  logic crc_clr, crc_mode, crc_en, crc_din; // crc requests
  logic tick, bend, rend, rmid, rise, flip, sub_on, bpsk, b, col, fend;
  logic ld, h1, h2, par_bad, sof_evt, pw_first, pw_mid;
  logic [7:0] len, rlen, nb, pw;
  logic [9:0] acc_sum, w;
  logic [2:0] fl_set, er_set;
  // ==========================================================
  // sequencing
  always_comb begin
    n = s;
    crc_clr = 1'b0;
    crc_mode = mode_b;
    crc_en = 1'b0;
    crc_din = 1'b0;
    fl_set = '0;
    er_set = '0;
    par_bad = 1'b0;
    sof_evt = 1'b0;
    fend = 1'b0;
    ld = 1'b0;
    nb = s.hold;
    b = 1'b0;
    col = 1'b0;
    w = '0;
    // carrier tick: 339 of every 500 ref cycles
    acc_sum = s.acc + NFCAB_ACC_STEP;
    tick = acc_sum >= NFCAB_ACC_WRAP;
    n.acc = tick ? acc_sum - NFCAB_ACC_WRAP : acc_sum;
    len = etu_len(s.tspeed); // [RL2]
    bend = tick && (s.etu == len - 8'h01);
    // host byte into the holding slot
    if (tx_valid && s.tx_ready) begin
      n.hold = tx_data;
      n.hold_v = 1'b1;
      n.last_in = tx_last;
    end
    if (s.tst != T_IDLE && tick) begin
      n.etu = bend ? 8'h00 : s.etu + 8'h01; // [RL2] [RL6]
    end
    if (bend) begin
      n.prv = s.cur;
    end
    unique case (s.tst)
      T_IDLE: begin
        n.etu = '0;
        n.cur = 1'b0; // sof: start pause in A, low in B
        n.prv = 1'b0;
        n.quiet = 1'b0;
        // half duplex: never start over a frame being received
        if (s.hold_v && s.rxs == R_IDLE) begin
          n.tst = T_SOF;
          n.tmode_b = mode_b;
          n.tspeed = speed;
          n.idx = mode_b ? NFCAB_B_SOF_IDX : 4'h0;
          n.src = 2'h0;
          crc_clr = 1'b1;
        end
      end
      T_SOF: if (bend) begin
        if (s.idx == 4'h0) begin
          ld = 1'b1;
          n.hold_v = 1'b0;
        end else begin
          n.idx = s.idx - 4'h1;
          n.cur = (s.idx - 4'h1) < 4'h2; // [RL6] two high bits close sof
        end
      end
      T_CHAR: if (bend) begin
        // crc covers data bits only, not parity/start/stop
        crc_en = (s.src == 2'h0) && (s.tmode_b ? (s.idx != 4'h0 && s.idx < NFCAB_B_STOP_IDX)
                                               : (s.idx < NFCAB_A_PAR_IDX)); // [RL4]
        crc_din = s.cur;
        if (s.idx == (s.tmode_b ? NFCAB_B_STOP_IDX : NFCAB_A_PAR_IDX)) begin
          if (s.src == 2'h0 && s.hold_v) begin
            ld = 1'b1;
            n.hold_v = 1'b0;
          end else if (s.src != 2'h2) begin
            // underrun closes the frame like a last byte
            ld = 1'b1;
            n.last_in = 1'b1;
            n.src = s.src + 2'h1;
            nb = (s.src == 2'h0 ? crc_bus.crc[7:0] : crc_bus.crc[15:8])
                 ^ {8{s.tmode_b}}; // [RL4] type B sends the complement
          end else begin
            n.tst = T_EOF;
            fl_set[NFCAB_F_TXD] = 1'b1; // [RL11]
            n.idx = s.tmode_b ? NFCAB_B_EOF_IDX : NFCAB_A_EOF_IDX;
            n.cur = 1'b0;
          end
        end else begin
          n.idx = s.idx + 4'h1;
          n.tsh = s.tsh >> 1;
          n.cur = s.tsh[1];
        end
      end
      T_EOF: if (bend) begin
        if (s.idx == 4'h0) begin
          n.tst = T_IDLE;
          n.last_in = 1'b0;
        end else begin
          n.idx = s.idx - 4'h1;
          n.quiet = !s.tmode_b; // type A ends with an unmodulated bit
        end
      end
    endcase
    if (ld) begin
      // A: data lsb first then odd parity; B: start 0, data, stop 1
      w = s.tmode_b ? {1'b1, nb, 1'b0} : {1'b0, ~^nb, nb}; // [RL5] [RL13]
      n.tst = T_CHAR;
      n.tsh = w;
      n.cur = w[0];
      n.idx = 4'h0;
    end
    n.tx_ready = !n.hold_v && !n.last_in;
    // modified Miller: 1 pauses mid-bit, 0 after 0 pauses at start
    pw = len >> 2; // pause width, quarter bit at every speed
    pw_first = s.etu < pw;
    pw_mid = s.etu >= (len >> 1) && s.etu < (len >> 1) + pw;
    n.mod_full = s.tst != T_IDLE && !s.tmode_b && !s.quiet
                 && (s.cur ? pw_mid : (!s.prv && pw_first)); // [RL1]
    n.mod_low10 = s.tst != T_IDLE && s.tmode_b && !s.cur; // [RL6]
    // ---- receive: pin sync, then subcarrier edge timing
    n.rs1 = rx_sub;
    n.rs2 = s.rs1;
    n.rs3 = s.rs2;
    rise = s.rs2 && !s.rs3;
    n.ivl = rise ? 6'h00 : (s.ivl == 6'h3F ? s.ivl : s.ivl + 6'h01);
    sub_on = s.ivl < NFCAB_IVL_OFF;
    // a rise interval far from one fc/16 period marks a phase jump
    flip = rise && sub_on && (s.ivl < NFCAB_IVL_LO || s.ivl > NFCAB_IVL_HI); // [RL7]
    if (flip) begin
      n.rph = !s.rph;
    end
    bpsk = mode_b || speed != 2'h0; // [RL3]
    rlen = etu_len(speed);
    rend = tick && s.retu == rlen - 8'h01;
    rmid = tick && s.retu == (rlen >> 1) - 8'h01;
    h1 = s.e1 >= NFCAB_MAN_EDGES;
    h2 = s.e2 >= NFCAB_MAN_EDGES;
    if (s.rxs == R_IDLE) begin
      n.retu = '0;
      n.e1 = '0;
      n.e2 = '0;
      if (s.tst == T_IDLE && sub_on && (!bpsk || flip)) begin
        sof_evt = 1'b1;
        fl_set[NFCAB_F_SOF] = 1'b1; // [RL10]
        n.rxs = mode_b ? R_SOF : R_DATA;
        n.refph = s.rph;
        n.rskip = !mode_b; // type A start bit carries no data
        n.ridx = '0;
        n.rany = 1'b0;
        crc_clr = 1'b1;
      end
    end else begin
      if (tick) begin
        n.retu = rend ? 8'h00 : s.retu + 8'h01;
      end
      if (rise && s.retu < (rlen >> 1) && s.e1 != 3'h7) begin
        n.e1 = s.e1 + 3'h1;
      end else if (rise && s.retu >= (rlen >> 1) && s.e2 != 3'h7) begin
        n.e2 = s.e2 + 3'h1;
      end
      if (rmid) begin
        n.samp = s.rph;
      end
      if (rend) begin
        n.e1 = '0;
        n.e2 = '0;
        b = bpsk ? (s.samp == s.refph) : h1; // [RL3] [RL7]
        col = !bpsk && h1 && h2; // both halves loaded
        if (bpsk ? !sub_on : (h1 == h2)) begin
          fend = 1'b1;
          er_set[NFCAB_E_FRM] = col;
        end else if (s.rxs == R_SOF) begin
          if (b) begin
            n.rxs = R_DATA;
          end
        end else if (s.rskip) begin
          n.rskip = 1'b0;
        end else if (!mode_b && s.ridx == NFCAB_A_PAR_IDX) begin
          par_bad = !(^{b, s.rsh}); // [RL13] [RL5]
          er_set[NFCAB_E_PAR] = par_bad;
          n.rx_data = s.rsh;
          n.rx_valid = 1'b1;
          n.rany = 1'b1;
          n.ridx = '0;
        end else if (mode_b && s.ridx == NFCAB_B_STOP_IDX) begin
          n.ridx = '0;
          if (b) begin
            n.rx_data = s.rsh;
            n.rx_valid = 1'b1;
            n.rany = 1'b1;
          end else if (s.rsh == 8'h00) begin
            fend = 1'b1; // ten low bits: end of frame
          end else begin
            er_set[NFCAB_E_FRM] = 1'b1;
          end
        end else if (mode_b && s.ridx == 4'h0) begin
          n.ridx = b ? 4'h0 : 4'h1; // wait for a start bit
        end else begin
          n.rsh = {b, s.rsh[7:1]};
          n.ridx = s.ridx + 4'h1;
          crc_en = 1'b1;
          crc_din = b;
        end
      end
      if (fend) begin
        n.rxs = R_IDLE;
        er_set[NFCAB_E_CRC] = s.rany && crc_bus.crc
                              != (mode_b ? NFCAB_CRC_RES_B : NFCAB_CRC_RES_A); // [RL4]
      end
    end
    n.rx_valid = n.rx_valid && rend;
    n.rx_end = fend;
    fl_set[NFCAB_F_ERR] = |er_set; // [RL12]
    // set wins over a clear in the same cycle
    n.flags = (s.flags & ~flag_clr) | fl_set;
    n.err = (s.err & ~{3{flag_clr[NFCAB_F_ERR]}}) | er_set;
    if (s.tst != T_IDLE) begin
      crc_mode = s.tmode_b;
    end
  end
  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= NFCAB_ST_RST;
    end else begin
      s <= n;
    end
  end
  assign crc_bus.clr = crc_clr;
  assign crc_bus.mode_b = crc_mode;
  assign crc_bus.en = crc_en;
  assign crc_bus.din = crc_din;
  nfcab_crc16 u_crc (.ref_clk(ref_clk), .rst(rst), .cb(crc_bus.core));
  assign tx_ready = s.tx_ready;
  assign rx_data = s.rx_data;
  assign rx_valid = s.rx_valid;
  assign rx_end = s.rx_end;
  assign mod_full = s.mod_full;
  assign mod_low10 = s.mod_low10;
  assign rx_frame_start_flag = s.flags[NFCAB_F_SOF];
  assign tx_done_flag = s.flags[NFCAB_F_TXD];
  assign rx_error_flag = s.flags[NFCAB_F_ERR];
  assign err_status = s.err;
  // ==========================================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_eof_entry;
    s.tst == T_CHAR ##1 s.tst == T_EOF;
  endsequence
  a_full_pause_typea: assert property (s.mod_full |-> !s.tmode_b) // [RL1]
    else $error("full pause in type B");
  a_bit_period_len: assert property (s.tst != T_IDLE |-> s.etu < etu_len(s.tspeed)) // [RL2]
    else $error("bit counter past period");
  a_nrz_low_level: assert property (s.tst == T_CHAR && s.tmode_b && !s.cur // [RL6]
    |=> s.mod_low10) else $error("NRZ zero not keyed");
  a_phase_stable: assert property (rise && s.ivl >= NFCAB_IVL_LO // [RL7]
    && s.ivl <= NFCAB_IVL_HI |=> $stable(s.rph)) else $error("phase flipped on period");
  a_tx_parity_odd: assert property (s.tst == T_CHAR && !s.tmode_b // [RL5]
    && s.idx == 4'h0 |-> ^s.tsh[8:0]) else $error("parity not odd");
  a_rx_parity_err: assert property (par_bad |=> s.err[NFCAB_E_PAR] // [RL13]
    && s.flags[NFCAB_F_ERR]) else $error("parity error lost");
  a_sof_flag_set: assert property (sof_evt |=> rx_frame_start_flag) // [RL10]
    else $error("frame start flag missing");
  a_tx_done_set: assert property (s_eof_entry |-> tx_done_flag) // [RL11]
    else $error("transmit done flag missing");
  a_err_flag_follow: assert property ($rose(|s.err) |-> rx_error_flag) // [RL12]
    else $error("error flag missing");
endmodule

//--- nfcab_crc16.sv
// nfcab_crc16: 16-bit reflected crc, one data bit per enabled cycle.
// assumes the codec clears it before each frame.
`timescale 1ns/100ps
module nfcab_crc16 import nfcab_pkg::*; (
  input wire logic ref_clk, // 20 MHz
  input wire logic rst, // async, high
  nfcab_crc_if.core cb // crc requests
);
  typedef struct packed {logic [15:0] crc;} nfcab_crc_st_type;
  nfcab_crc_st_type s, n; // state and next
  // ==========================================================
  // update
  always_comb begin
    n = s;
    if (cb.clr) begin
      n.crc = cb.mode_b ? NFCAB_CRC_INIT_B : NFCAB_CRC_INIT_A; // [RL4]
    end else if (cb.en) begin
      n.crc = (s.crc >> 1) ^ ((s.crc[0] ^ cb.din) ? NFCAB_CRC_POLY : 16'h0000); // [RL4]
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign cb.crc = s.crc;
  // ==========================================================
  // checks
  a_crc_seed_load: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
    cb.clr |=> cb.crc == ($past(cb.mode_b) ? NFCAB_CRC_INIT_B : NFCAB_CRC_INIT_A))
    else $error("crc seed not loaded");
endmodule

//--- nfcab_crc_if.sv
// nfcab_crc_if: bit-serial crc request and result between codec and crc unit.
// assumes one clock shared by both ends.
`timescale 1ns/100ps
interface nfcab_crc_if;
  logic clr; // load seed
  logic mode_b; // seed select
  logic en; // shift one bit
  logic din; // bit value
  logic [15:0] crc; // running register
  modport core(input clr, mode_b, en, din, output crc);
  modport user(output clr, mode_b, en, din, input crc);
endinterface

//--- nfcab_pkg.sv
// nfcab_pkg: constants and types shared by the type A/B frame codec.
// assumes a 20 MHz reference clock; the 13.56 MHz carrier is rebuilt from it.
package nfcab_pkg;
  // ==========================================================
  // carrier rebuilt from the reference clock
  localparam int NFCAB_FC_KHZ = 13560; // carrier, 13.56 MHz
  localparam int NFCAB_REF_KHZ = 20000; // ref_clk, 20 MHz
  localparam logic [9:0] NFCAB_ACC_STEP = 10'(NFCAB_FC_KHZ / 40); // carrier phase step
  localparam logic [9:0] NFCAB_ACC_WRAP = 10'(NFCAB_REF_KHZ / 40); // phase wrap
  localparam logic [7:0] NFCAB_ETU_106 = 8'h80; // carrier cycles per bit at 106k
  localparam int NFCAB_SUBC_FC = 16; // subcarrier period in carrier cycles
  localparam logic [5:0] NFCAB_SUBC_REF =
    6'((NFCAB_SUBC_FC * NFCAB_REF_KHZ) / NFCAB_FC_KHZ); // subcarrier period, ref cycles
  localparam logic [5:0] NFCAB_IVL_LO = NFCAB_SUBC_REF - 6'h06; // shorter: phase jump
  localparam logic [5:0] NFCAB_IVL_HI = NFCAB_SUBC_REF + 6'h07; // longer: phase jump
  localparam logic [5:0] NFCAB_IVL_OFF = 6'(2 * NFCAB_SUBC_REF); // silence threshold
  localparam logic [2:0] NFCAB_MAN_EDGES = 3'h3; // rises marking a loaded half-bit
  // ==========================================================
  // crc and framing
  localparam logic [15:0] NFCAB_CRC_POLY = 16'h8408; // reflected polynomial
  localparam logic [15:0] NFCAB_CRC_INIT_A = 16'h6363;
  localparam logic [15:0] NFCAB_CRC_INIT_B = 16'hFFFF;
  localparam logic [15:0] NFCAB_CRC_RES_A = 16'h0000; // residue over data plus crc
  localparam logic [15:0] NFCAB_CRC_RES_B = 16'hF0B8;
  localparam logic [3:0] NFCAB_B_SOF_IDX = 4'hB; // ten low bits then two high
  localparam logic [3:0] NFCAB_B_EOF_IDX = 4'h9; // ten low bits
  localparam logic [3:0] NFCAB_A_EOF_IDX = 4'h1; // logic 0 then an unmodulated bit
  localparam logic [3:0] NFCAB_A_PAR_IDX = 4'h8; // parity bit position
  localparam logic [3:0] NFCAB_B_STOP_IDX = 4'h9; // stop bit position
  localparam int NFCAB_F_SOF = 0; // flag bit: frame start
  localparam int NFCAB_F_TXD = 1; // flag bit: transmit done
  localparam int NFCAB_F_ERR = 2; // flag bit: receive error
  localparam int NFCAB_E_PAR = 0; // error bit: parity
  localparam int NFCAB_E_CRC = 1; // error bit: crc
  localparam int NFCAB_E_FRM = 2; // error bit: framing or collision
  // ==========================================================
  // state types
  typedef enum logic [3:0] {
    T_IDLE = 4'b0001, T_SOF = 4'b0010, T_CHAR = 4'b0100, T_EOF = 4'b1000
  } nfcab_tx_type;
  typedef enum logic [2:0] {R_IDLE = 3'b001, R_SOF = 3'b010, R_DATA = 3'b100} nfcab_rx_type;
  typedef struct packed {
    logic [9:0] acc; // carrier phase
    nfcab_tx_type tst; // transmit sequencer
    logic tmode_b; // frame mode, latched at start
    logic [1:0] tspeed; // frame speed, latched at start
    logic [7:0] etu; // carrier count within bit
    logic [3:0] idx; // bit index
    logic [1:0] src; // 0 data, 1 crc low, 2 crc high
    logic [9:0] tsh; // character shifter
    logic cur, prv, quiet; // bit on air, previous bit, no pause
    logic [7:0] hold; // host byte waiting
    logic hold_v, last_in, tx_ready;
    logic mod_full, mod_low10; // modulator controls
    logic rs1, rs2, rs3; // pin sync and edge history
    logic [5:0] ivl; // ref cycles since last rise
    logic rph, refph, samp; // subcarrier phase tracking
    nfcab_rx_type rxs; // receive sequencer
    logic [7:0] retu; // receive bit timer
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic [2:0] e1, e2; // rises per half-bit
    logic rskip, rany;
    logic [7:0] rx_data;
    logic rx_valid, rx_end;
    logic [2:0] err, flags;
  } nfcab_st_type;
  // rise interval starts saturated: a zero would read as a live subcarrier
  // and open a false receive frame straight after reset
  localparam nfcab_st_type NFCAB_ST_RST = '{tst: T_IDLE, rxs: R_IDLE, ivl: 6'h3F, default: '0};
  // carrier cycles per bit for a speed code
  function automatic logic [7:0] etu_len(input logic [1:0] sp);
    etu_len = NFCAB_ETU_106 >> sp;
  endfunction
endpackage

//--- testbench.sv
// testbench: self-checking bench for the type A/B frame codec.
// assumes nfcab_codec alone; the card model sits on the rf pins.
`timescale 1ns/100ps
module testbench;
  // ==========================================================
  // stimulus and design outputs
  logic ref_clk = 1'b0; // 20 MHz
  logic rst = 1'b1; // held at start
  logic mode_b = 1'b0; // type select
  logic [1:0] speed = 2'h0; // speed code
  logic tx_valid = 1'b0; // byte offered
  logic [7:0] tx_data = 8'h00; // byte
  logic tx_last = 1'b0; // last byte
  logic [2:0] flag_clr = 3'h0; // flag clears
  logic rx_sub, tx_ready, rx_valid, rx_end, mod_full, mod_low10;
  logic rx_frame_start_flag, tx_done_flag, rx_error_flag;
  logic [7:0] rx_data;
  logic [2:0] err_status;
  wire logic [10:0] outs = {tx_ready, rx_valid, rx_end, mod_full, mod_low10,
    rx_frame_start_flag, tx_done_flag, rx_error_flag, err_status}; // all outputs but rx_data
  int fail_count = 0;
  int check_count = 0;
  int n_end = 0; // rx_end pulses
  logic [7:0] rxq [$]; // received bytes
  typedef struct {logic mb; logic [1:0] sp; int fc;} nfcab_row_type;
  // mode, speed, carrier cycles of first keyed span
  nfcab_row_type rows [0:7] = '{'{1'b0, 2'h0, 32}, '{1'b0, 2'h1, 16}, '{1'b0, 2'h2, 8},
    '{1'b0, 2'h3, 4}, '{1'b1, 2'h0, 1280}, '{1'b1, 2'h1, 640}, '{1'b1, 2'h2, 320},
    '{1'b1, 2'h3, 160}};
  always #25 ref_clk = ~ref_clk;
  nfcab_codec nfcab_codec_i (.ref_clk(ref_clk), .rst(rst), .mode_b(mode_b), .speed(speed),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_sub(rx_sub), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
    .mod_full(mod_full), .mod_low10(mod_low10), .flag_clr(flag_clr),
    .rx_frame_start_flag(rx_frame_start_flag), .tx_done_flag(tx_done_flag),
    .rx_error_flag(rx_error_flag), .err_status(err_status));
  nfcab_card_model nfcab_card_model_i (.ref_clk(ref_clk), .mod_full(mod_full),
    .mod_low10(mod_low10), .rx_sub(rx_sub));
  // collects every received byte and frame end
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rx_end === 1'b1) n_end++;
  end
  // ==========================================================
  // compare helpers and closing
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // timing measured against the rebuilt carrier, so a small slack
  task automatic near(input string nm, input int exp, input int got, input int tol);
    check_count++;
    if (got > exp + tol || got < exp - tol) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic int rc(input int fc);
    return $rtoi(real'(fc) * 20000.0 / 13560.0 + 0.5);
  endfunction
  // expected type A frame bits: sof 0, byte, crc, odd parity each
  function automatic logic [39:0] a_frame(input logic [7:0] b);
    logic [7:0] q [$];
    logic [15:0] c;
    logic [39:0] v;
    int k;
    q = '{b};
    c = nfcab_card_model_i.crc_a(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    v = '0;
    k = 1;
    foreach (q[i]) begin
      for (int j = 0; j < 8; j++) v[k + j] = q[i][j];
      v[k + 8] = ~^q[i];
      k = k + 9;
    end
    return v;
  endfunction
  // ==========================================================
  // host side drivers
  task automatic clr(input logic [2:0] v);
    @(posedge ref_clk);
    flag_clr <= v;
    @(posedge ref_clk);
    flag_clr <= 3'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  // one-byte frame; waits until the slot reopens after end of frame
  task automatic tx_frame(input logic mb, input logic [1:0] sp, input logic [7:0] b);
    int n;
    @(posedge ref_clk);
    nfcab_card_model_i.clear();
    mode_b <= mb;
    speed <= sp;
    tx_data <= b;
    tx_last <= 1'b1;
    tx_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 100);
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    @(posedge ref_clk);
    chk("tx_ready after take", 40'h0, 40'(tx_ready));
    n = 0;
    while (tx_ready !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("tx_ready after frame", 40'h1, 40'(tx_ready));
    repeat (4) @(posedge ref_clk);
  endtask
  // card answers 50 00 plus crc; crc_x spoils the crc
  task automatic rx_case(input int bad_par, input logic [15:0] crc_x, input logic [2:0] e);
    logic [7:0] q [$];
    logic [15:0] c;
    q = '{8'h50, 8'h00};
    c = nfcab_card_model_i.crc_a(q) ^ crc_x;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    @(posedge ref_clk);
    mode_b <= 1'b0;
    speed <= 2'h0;
    rxq.delete();
    n_end = 0;
    nfcab_card_model_i.send_a(q, bad_par);
    repeat (20) @(posedge ref_clk);
    chk("rx byte count", 40'd4, 40'(rxq.size()));
    foreach (q[i]) chk("rx_data", 40'(q[i]), 40'(rxq[i]));
    chk("rx_end count", 40'd1, 40'(n_end));
    chk("rx_frame_start_flag", 40'h1, 40'(rx_frame_start_flag));
    chk("err_status", 40'(e), 40'(err_status));
    chk("rx_error_flag", 40'(|e), 40'(rx_error_flag));
    clr(3'h7);
    chk("flags cleared", 40'h400, 40'(outs)); // tx_ready stays high when idle
    $display("test rx case done");
  endtask
  // ==========================================================
  // main sequence: reset, table of frames, then awkward cases
  initial begin
    repeat (5) @(posedge ref_clk);
    chk("outputs in reset", 40'h0, 40'(outs));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("tx_ready after reset", 40'h1, 40'(tx_ready));
    $display("test reset done");
    for (int r = 0; r < 8; r++) begin
      tx_frame(rows[r].mb, rows[r].sp, 8'hFF);
      if (rows[r].mb) begin
        near("sof low run", rc(rows[r].fc), nfcab_card_model_i.run10, 3);
        chk("full pauses in B", 40'h0, 40'(nfcab_card_model_i.n_full));
      end else begin
        near("pause width", rc(rows[r].fc), nfcab_card_model_i.w0, 2);
        near("bit period", rc(rows[r].fc * 4), nfcab_card_model_i.ps[2]
          - nfcab_card_model_i.ps[1], 2);
        chk("ten percent in A", 40'h0, 40'(nfcab_card_model_i.n_low));
        chk("miller frame", a_frame(8'hFF), nfcab_card_model_i.decode(rows[r].sp));
      end
      chk("tx_done_flag", 40'h1, 40'(tx_done_flag));
      clr(3'h2);
      chk("tx_done_flag cleared", 40'h0, 40'(tx_done_flag));
      $display("test row %0d done", r);
    end
    rx_case(-1, 16'h0000, 3'h0);
    rx_case(1, 16'h0000, 3'h1);
    rx_case(-1, 16'h0001, 3'h2);
    // bpsk at 212k: a phase jump in a running subcarrier opens the frame
    @(posedge ref_clk);
    speed <= 2'h1;
    n_end = 0;
    repeat (4) nfcab_card_model_i.half(1'b1);
    #590.0;
    repeat (8) nfcab_card_model_i.half(1'b1);
    repeat (200) @(posedge ref_clk);
    chk("bpsk rx_frame_start_flag", 40'h1, 40'(rx_frame_start_flag));
    chk("bpsk rx_end count", 40'd1, 40'(n_end));
    chk("bpsk err_status", 40'h0, 40'(err_status));
    clr(3'h7);
    $display("test bpsk done");
    @(posedge ref_clk);
    tx_data <= 8'hFF;
    tx_last <= 1'b1;
    tx_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    tx_valid <= 1'b0;
    repeat (100) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("outputs in mid reset", 40'h0, 40'(outs));
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("tx_ready after reset", 40'h1, 40'(tx_ready));
    $display("test mid reset done");
    wrap_up();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (95000) @(posedge ref_clk);
    fail_count++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule
